// [design/fpg_pkg.sv]
// Shared constants of the four channel pulse generator
package fpg_pkg;
	// ==========================================================
	// Geometry
	localparam int CHANNELS = 4;
	localparam int CNT_W    = 30;
	localparam int ADDR_W   = 8;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CH0    = 8'h10;
	localparam logic [7:0] CH_STRIDE  = 8'h10;
	localparam logic [3:0] OFS_PERIOD = 4'h0;
	localparam logic [3:0] OFS_HIGH   = 4'h4;
	localparam logic [3:0] OFS_COUNT  = 4'h8;
	localparam logic [3:0] OFS_PHASE  = 4'hC;
	// ==========================================================
	// Control and status register fields
	localparam int CTRL_RUN_LSB  = 0;
	localparam int CTRL_MODE_LSB = 4;
	localparam int CTRL_CLKSEL   = 8;
	localparam int CTRL_SYNC     = 9;
	localparam int CTRL_SYNC_RUN = 10;
	localparam int STAT_DONE_LSB = 4;
	// ==========================================================
	// Reset values and shortest period
	localparam logic [31:0]      CTRL_RST   = 32'h0000_0000;
	localparam logic [CNT_W-1:0] PERIOD_RST = 30'h0000_0002;
	localparam logic [CNT_W-1:0] HIGH_RST   = 30'h0000_0001;
	localparam logic [CNT_W-1:0] COUNT_RST  = 30'h0000_0001;
	localparam logic [CNT_W-1:0] MIN_PERIOD = 30'h0000_0002;
	// ==========================================================
	// Source clock ticks from the 250 MHz system clock
	localparam int SYS_KHZ     = 250000;
	localparam int SRC_A_KHZ   = 100000;
	localparam int SRC_B_KHZ   = 148500;
	localparam int ACC_W       = 10;
	localparam int ACC_MOD_I   = 500;
	localparam logic [ACC_W-1:0] ACC_MOD   = ACC_W'(ACC_MOD_I);
	localparam logic [ACC_W-1:0] INC_SRC_A = ACC_W'(SRC_A_KHZ * ACC_MOD_I / SYS_KHZ);
	localparam logic [ACC_W-1:0] INC_SRC_B = ACC_W'(SRC_B_KHZ * ACC_MOD_I / SYS_KHZ);
	// ==========================================================
	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [design/fpg_channel.sv]
// One pulse output channel with shadowed period and high count
module fpg_channel (
	input  wire logic                    i_clk,    // System clock
	input  wire logic                    i_nrst,   // Async reset, active low
	input  wire logic                    i_tick,   // Source clock enable
	input  wire logic                    i_run,    // Channel run level
	input  wire logic                    i_mode,   // Pulse count select
	input  wire logic [fpg_pkg::CNT_W-1:0] i_period, // Period in source cycles
	input  wire logic [fpg_pkg::CNT_W-1:0] i_high,   // High cycles per period
	input  wire logic [fpg_pkg::CNT_W-1:0] i_count,  // Periods in count mode
	input  wire logic [fpg_pkg::CNT_W-1:0] i_phase,  // Start offset
	output logic                         o_pwm,    // Pulse output
	output logic                         o_active, // Channel counting
	output logic                         o_done    // Count mode finished
);
	typedef logic [fpg_pkg::CNT_W-1:0] fpg_cnt_t;

	fpg_cnt_t cnt_q, cnt_d, per_q, per_d, high_q, high_d, num_q, num_d, done_cnt_q, done_cnt_d;
	logic     act_q, act_d, done_q, done_d, pwm_q, pwm_d, run_q, mode_q, mode_d;

	// ==========================================================
	// Counter
	always_comb begin
		cnt_d      = cnt_q;
		per_d      = per_q;
		high_d     = high_q;
		num_d      = num_q;
		mode_d     = mode_q;
		done_cnt_d = done_cnt_q;
		act_d      = act_q;
		done_d     = done_q;
		pwm_d      = pwm_q;
		if (!i_run) begin
			act_d  = 1'b0;
			done_d = 1'b0;
			pwm_d  = 1'b0;
		end else if (!run_q) begin
			// Start: capture settings, begin at the phase offset
			act_d      = 1'b1;
			done_d     = 1'b0;
			per_d      = (i_period < fpg_pkg::MIN_PERIOD) ? fpg_pkg::MIN_PERIOD : i_period;
			high_d     = i_high;
			num_d      = i_count;
			mode_d     = i_mode;
			cnt_d      = (i_phase < per_d) ? i_phase : '0;
			done_cnt_d = '0;
		end else if (act_q && i_tick) begin
			pwm_d = (cnt_q < high_q);
			if (cnt_q >= per_q - 30'h0000_0001) begin
				cnt_d      = '0;
				per_d      = (i_period < fpg_pkg::MIN_PERIOD) ? fpg_pkg::MIN_PERIOD : i_period;
				high_d     = i_high;
				done_cnt_d = done_cnt_q + 30'h0000_0001;
				if (mode_q && (done_cnt_q + 30'h0000_0001 >= num_q)) begin
					act_d  = 1'b0;
					done_d = 1'b1;
				end
			end else begin
				cnt_d = cnt_q + 30'h0000_0001;
			end
		end else if (!act_q) begin
			pwm_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_q      <= '0;
			per_q      <= fpg_pkg::PERIOD_RST;
			high_q     <= fpg_pkg::HIGH_RST;
			num_q      <= fpg_pkg::COUNT_RST;
			mode_q     <= 1'b0;
			done_cnt_q <= '0;
			act_q      <= 1'b0;
			done_q     <= 1'b0;
			pwm_q      <= 1'b0;
			run_q      <= 1'b0;
		end else begin
			cnt_q      <= cnt_d;
			per_q      <= per_d;
			high_q     <= high_d;
			num_q      <= num_d;
			mode_q     <= mode_d;
			done_cnt_q <= done_cnt_d;
			act_q      <= act_d;
			done_q     <= done_d;
			pwm_q      <= pwm_d;
			run_q      <= i_run;
		end
	end

	assign o_pwm    = pwm_q;
	assign o_active = act_q;
	assign o_done   = done_q;
endmodule

// [design/fpg_top.sv]
// Four channel pulse generator with AXI4-Lite register slave
// Operation
// - four independent channels, separate settings and counters
// - source 100 MHz after reset, or 148.5 MHz
// - 30-bit counter, period and high count
// - shortest period two source cycles
// - longest period full 30-bit range
// - mode 0 repeats until stopped
// - mode 1 emits programmed period count
// - sync mode starts all together, offsets
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
module fpg_top (
	input  wire logic        I_CLK_SYS,       // 250 MHz system clock
	input  wire logic        I_NRST,          // Async reset, active low
	input  wire logic [7:0]  I_S_AXI_AWADDR,  // Write address
	input  wire logic        I_S_AXI_AWVALID, // Write address valid
	output logic             O_S_AXI_AWREADY, // Write address ready
	input  wire logic [31:0] I_S_AXI_WDATA,   // Write data
	input  wire logic [3:0]  I_S_AXI_WSTRB,   // Write byte enables
	input  wire logic        I_S_AXI_WVALID,  // Write data valid
	output logic             O_S_AXI_WREADY,  // Write data ready
	output logic [1:0]       O_S_AXI_BRESP,   // Write response
	output logic             O_S_AXI_BVALID,  // Write response valid
	input  wire logic        I_S_AXI_BREADY,  // Write response ready
	input  wire logic [7:0]  I_S_AXI_ARADDR,  // Read address
	input  wire logic        I_S_AXI_ARVALID, // Read address valid
	output logic             O_S_AXI_ARREADY, // Read address ready
	output logic [31:0]      O_S_AXI_RDATA,   // Read data
	output logic [1:0]       O_S_AXI_RRESP,   // Read response
	output logic             O_S_AXI_RVALID,  // Read data valid
	input  wire logic        I_S_AXI_RREADY,  // Read data ready
	output logic [3:0]       O_PWM            // Pulse outputs
);
	localparam int NCH = fpg_pkg::CHANNELS;
	typedef logic [fpg_pkg::CNT_W-1:0] fpg_cnt_t;

	// ==========================================================
	// Register state
	logic [31:0] ctrl_q, ctrl_d;
	fpg_cnt_t    per_q [NCH];
	fpg_cnt_t    per_d [NCH];
	fpg_cnt_t    high_q [NCH];
	fpg_cnt_t    high_d [NCH];
	fpg_cnt_t    num_q [NCH];
	fpg_cnt_t    num_d [NCH];
	fpg_cnt_t    ph_q [NCH];
	fpg_cnt_t    ph_d [NCH];
	logic [NCH-1:0] act, done, pwm, run;

	// Bus state
	logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, bvalid_q, bvalid_d, arrdy_q, arrdy_d;
	logic        rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        awhave_q, awhave_d, whave_q, whave_d;

	// Source tick accumulator
	logic [fpg_pkg::ACC_W-1:0] acc_q, acc_d;
	logic                      tick_q, tick_d;

	// ==========================================================
	// Source clock enable
	always_comb begin
		logic [fpg_pkg::ACC_W:0] sum;
		sum = '0;
		sum = {1'b0, acc_q} + {1'b0, ctrl_q[fpg_pkg::CTRL_CLKSEL] ? fpg_pkg::INC_SRC_B
			: fpg_pkg::INC_SRC_A};
		if (sum >= {1'b0, fpg_pkg::ACC_MOD}) begin
			acc_d  = fpg_pkg::ACC_W'(sum - {1'b0, fpg_pkg::ACC_MOD});
			tick_d = 1'b1;
		end else begin
			acc_d  = sum[fpg_pkg::ACC_W-1:0];
			tick_d = 1'b0;
		end
	end

	// ==========================================================
	// Channels
	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			assign run[c] = ctrl_q[fpg_pkg::CTRL_SYNC] ? ctrl_q[fpg_pkg::CTRL_SYNC_RUN]
				: ctrl_q[fpg_pkg::CTRL_RUN_LSB + c];
			fpg_channel u_ch (
				.i_clk    (I_CLK_SYS),
				.i_nrst   (I_NRST),
				.i_tick   (tick_q),
				.i_run    (run[c]),
				.i_mode   (ctrl_q[fpg_pkg::CTRL_MODE_LSB + c]),
				.i_period (per_q[c]),
				.i_high   (high_q[c]),
				.i_count  (num_q[c]),
				.i_phase  (ph_q[c]),
				.o_pwm    (pwm[c]),
				.o_active (act[c]),
				.o_done   (done[c])
			);
		end
	endgenerate

	// ==========================================================
	// Bus slave and register file
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	always_comb begin
		int  ch;
		logic hit;
		ch   = 0;
		hit  = 1'b0;
		ctrl_d = ctrl_q;
		per_d  = per_q;
		high_d = high_q;
		num_d  = num_q;
		ph_d   = ph_q;
		awaddr_d = awaddr_q;
		wdata_d  = wdata_q;
		wstrb_d  = wstrb_q;
		awhave_d = awhave_q;
		whave_d  = whave_q;
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		if (I_S_AXI_AWVALID && awrdy_q) begin
			awaddr_d = I_S_AXI_AWADDR;
			awhave_d = 1'b1;
		end
		if (I_S_AXI_WVALID && wrdy_q) begin
			wdata_d  = I_S_AXI_WDATA;
			wstrb_d  = I_S_AXI_WSTRB;
			whave_d  = 1'b1;
		end
		if (bvalid_q && I_S_AXI_BREADY) begin
			bvalid_d = 1'b0;
		end
		if (awhave_q && whave_q && !bvalid_q) begin
			awhave_d = 1'b0;
			whave_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = fpg_pkg::RESP_OKAY;
			ch = int'((awaddr_q - fpg_pkg::OFS_CH0) >> 4);
			if (awaddr_q[1:0] != 2'h0) begin
				bresp_d = fpg_pkg::RESP_SLVERR;
			end else if (awaddr_q == fpg_pkg::OFS_CTRL) begin
				ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
			end else if (awaddr_q == fpg_pkg::OFS_STATUS) begin
				bresp_d = fpg_pkg::RESP_OKAY;
			end else if (awaddr_q >= fpg_pkg::OFS_CH0 && ch < NCH) begin
				unique case (awaddr_q[3:0])
					fpg_pkg::OFS_PERIOD: per_d[ch]  = fpg_cnt_t'(merge(32'(per_q[ch]), wdata_q, wstrb_q));
					fpg_pkg::OFS_HIGH:   high_d[ch] = fpg_cnt_t'(merge(32'(high_q[ch]), wdata_q, wstrb_q));
					fpg_pkg::OFS_COUNT:  num_d[ch]  = fpg_cnt_t'(merge(32'(num_q[ch]), wdata_q, wstrb_q));
					default:             ph_d[ch]   = fpg_cnt_t'(merge(32'(ph_q[ch]), wdata_q, wstrb_q));
				endcase
			end else begin
				bresp_d = fpg_pkg::RESP_SLVERR;
			end
		end
		if (rvalid_q && I_S_AXI_RREADY) begin
			rvalid_d = 1'b0;
		end
		if (I_S_AXI_ARVALID && arrdy_q) begin
			rvalid_d = 1'b1;
			rresp_d  = fpg_pkg::RESP_OKAY;
			rdata_d  = 32'h0000_0000;
			ch = int'((I_S_AXI_ARADDR - fpg_pkg::OFS_CH0) >> 4);
			hit = (I_S_AXI_ARADDR >= fpg_pkg::OFS_CH0) && (ch < NCH);
			if (I_S_AXI_ARADDR[1:0] != 2'h0) begin
				rresp_d = fpg_pkg::RESP_SLVERR;
			end else if (I_S_AXI_ARADDR == fpg_pkg::OFS_CTRL) begin
				rdata_d = ctrl_q;
			end else if (I_S_AXI_ARADDR == fpg_pkg::OFS_STATUS) begin
				rdata_d = {24'h00_0000, done, act};
			end else if (hit) begin
				unique case (I_S_AXI_ARADDR[3:0])
					fpg_pkg::OFS_PERIOD: rdata_d = {2'h0, per_q[ch]};
					fpg_pkg::OFS_HIGH:   rdata_d = {2'h0, high_q[ch]};
					fpg_pkg::OFS_COUNT:  rdata_d = {2'h0, num_q[ch]};
					default:             rdata_d = {2'h0, ph_q[ch]};
				endcase
			end else begin
				rresp_d = fpg_pkg::RESP_SLVERR;
			end
		end
		awrdy_d = !awhave_d;
		wrdy_d  = !whave_d;
		arrdy_d = !rvalid_d;
	end

	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			ctrl_q   <= fpg_pkg::CTRL_RST;
			for (int c = 0; c < NCH; c++) begin
				per_q[c]  <= fpg_pkg::PERIOD_RST;
				high_q[c] <= fpg_pkg::HIGH_RST;
				num_q[c]  <= fpg_pkg::COUNT_RST;
				ph_q[c]   <= '0;
			end
			awaddr_q <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
			awhave_q <= 1'b0;
			whave_q  <= 1'b0;
			awrdy_q  <= 1'b0;
			wrdy_q   <= 1'b0;
			arrdy_q  <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q  <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q  <= 2'h0;
			rdata_q  <= 32'h0000_0000;
			acc_q    <= '0;
			tick_q   <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			per_q    <= per_d;
			high_q   <= high_d;
			num_q    <= num_d;
			ph_q     <= ph_d;
			awaddr_q <= awaddr_d;
			wdata_q  <= wdata_d;
			wstrb_q  <= wstrb_d;
			awhave_q <= awhave_d;
			whave_q  <= whave_d;
			awrdy_q  <= awrdy_d;
			wrdy_q   <= wrdy_d;
			arrdy_q  <= arrdy_d;
			bvalid_q <= bvalid_d;
			bresp_q  <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q  <= rresp_d;
			rdata_q  <= rdata_d;
			acc_q    <= acc_d;
			tick_q   <= tick_d;
		end
	end

	assign O_S_AXI_AWREADY = awrdy_q;
	assign O_S_AXI_WREADY  = wrdy_q;
	assign O_S_AXI_BVALID  = bvalid_q;
	assign O_S_AXI_BRESP   = bresp_q;
	assign O_S_AXI_ARREADY = arrdy_q;
	assign O_S_AXI_RVALID  = rvalid_q;
	assign O_S_AXI_RRESP   = rresp_q;
	assign O_S_AXI_RDATA   = rdata_q;
	assign O_PWM           = pwm;
endmodule

// [sim/fpg_props.sv]
// Concurrent checks on the pulse generator register bus and status
module fpg_props (
	input wire logic        I_CLK_SYS,       // Clock
	input wire logic        I_NRST,          // Reset
	input wire logic        I_S_AXI_AWVALID, // AW valid
	input wire logic        O_S_AXI_AWREADY, // AW ready
	input wire logic        I_S_AXI_WVALID,  // W valid
	input wire logic        O_S_AXI_WREADY,  // W ready
	input wire logic [1:0]  O_S_AXI_BRESP,   // B resp
	input wire logic        O_S_AXI_BVALID,  // B valid
	input wire logic        I_S_AXI_BREADY,  // B ready
	input wire logic [7:0]  I_S_AXI_ARADDR,  // AR addr
	input wire logic        I_S_AXI_ARVALID, // AR valid
	input wire logic        O_S_AXI_ARREADY, // AR ready
	input wire logic [31:0] O_S_AXI_RDATA,   // R data
	input wire logic        O_S_AXI_RVALID,  // R valid
	input wire logic        I_S_AXI_RREADY   // R ready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLK_SYS);
	endclocking
	default disable iff (!I_NRST);
	// ==========================================================
	// Sequences
	sequence s_wr_take;
		I_S_AXI_AWVALID && O_S_AXI_AWREADY && I_S_AXI_WVALID && O_S_AXI_WREADY;
	endsequence
	sequence s_stat_rd;
		I_S_AXI_ARVALID && O_S_AXI_ARREADY && I_S_AXI_ARADDR == fpg_pkg::OFS_STATUS
			##1 O_S_AXI_RVALID;
	endsequence
	// ==========================================================
	// Assertions
	AST_WR_ANS: assert property (s_wr_take |-> ##[1:3] O_S_AXI_BVALID)
		else $error("write answer late");
	AST_RD_ANS: assert property (I_S_AXI_ARVALID && O_S_AXI_ARREADY |=> O_S_AXI_RVALID)
		else $error("read answer late");
	AST_B_HOLD: assert property (O_S_AXI_BVALID && !I_S_AXI_BREADY
		|=> O_S_AXI_BVALID && $stable(O_S_AXI_BRESP))
		else $error("write answer dropped");
	AST_R_HOLD: assert property (O_S_AXI_RVALID && !I_S_AXI_RREADY
		|=> O_S_AXI_RVALID && $stable(O_S_AXI_RDATA))
		else $error("read answer dropped");
	AST_AR_BUSY: assert property (O_S_AXI_RVALID |-> !O_S_AXI_ARREADY)
		else $error("read taken while answer pending");
	AST_AW_BUSY: assert property (I_S_AXI_AWVALID && O_S_AXI_AWREADY |=> !O_S_AXI_AWREADY)
		else $error("write address taken twice without commit");
	AST_B_CODE: assert property (O_S_AXI_BVALID |-> O_S_AXI_BRESP inside {2'h0, 2'h2})
		else $error("illegal write response");
	AST_R_TOP: assert property (O_S_AXI_RVALID |-> O_S_AXI_RDATA[31:30] == 2'h0)
		else $error("read bits above 30 set");
	AST_STAT_DONE: assert property (s_stat_rd |->
		(O_S_AXI_RDATA[7:4] & O_S_AXI_RDATA[3:0]) == 4'h0)
		else $error("channel both done and active");
endmodule

bind fpg_top fpg_props fpg_props_i (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST),
	.I_S_AXI_AWVALID(I_S_AXI_AWVALID), .O_S_AXI_AWREADY(O_S_AXI_AWREADY),
	.I_S_AXI_WVALID(I_S_AXI_WVALID), .O_S_AXI_WREADY(O_S_AXI_WREADY),
	.O_S_AXI_BRESP(O_S_AXI_BRESP), .O_S_AXI_BVALID(O_S_AXI_BVALID),
	.I_S_AXI_BREADY(I_S_AXI_BREADY), .I_S_AXI_ARADDR(I_S_AXI_ARADDR),
	.I_S_AXI_ARVALID(I_S_AXI_ARVALID), .O_S_AXI_ARREADY(O_S_AXI_ARREADY),
	.O_S_AXI_RDATA(O_S_AXI_RDATA), .O_S_AXI_RVALID(O_S_AXI_RVALID),
	.I_S_AXI_RREADY(I_S_AXI_RREADY));

// [sim/fpg_load.sv]
// Passive load on the pulse pins that times each output
module fpg_load (
	input  wire logic       i_clk,     // Clock
	input  wire logic       i_clr,     // Clear edge counts
	input  wire logic [3:0] i_pwm,     // Pulse pins
	output int              o_rise[4], // Rising edges
	output int              o_gap[4],  // Rise to rise
	output int              o_high[4], // Rise to fall
	output int              o_t[4]     // Last rise time
);
	timeunit 1ns;
	timeprecision 1ps;
	int         now = 0;
	logic [3:0] prev = 4'h0;
	always @(posedge i_clk) begin
		now++;
		prev <= i_pwm;
		for (int c = 0; c < 4; c++) begin
			if (i_pwm[c] && !prev[c]) begin
				o_rise[c]++;
				o_gap[c] = now - o_t[c];
				o_t[c] = now;
			end
			if (!i_pwm[c] && prev[c])
				o_high[c] = now - o_t[c];
			if (i_clr)
				o_rise[c] = 0;
		end
	end
endmodule

// [sim/fpg_tb_top.sv]
// Self-checking bench of the four channel pulse generator
module fpg_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, nrst, awv, wv, bre, arv, rre, clr, awr, wrdy, bv, arr, rv;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat, d;
	logic [31:0] v[4];
	logic [3:0]  ws, pwm;
	logic [1:0]  bresp, rresp, r;
	int          err_count, n_compared, rise[4], gap[4], hi[4], tr[4], pp[4], hh[4];
	fpg_top fpg_top_i (.I_CLK_SYS(clk), .I_NRST(nrst), .I_S_AXI_AWADDR(awa),
		.I_S_AXI_AWVALID(awv), .O_S_AXI_AWREADY(awr), .I_S_AXI_WDATA(wd),
		.I_S_AXI_WSTRB(ws), .I_S_AXI_WVALID(wv), .O_S_AXI_WREADY(wrdy),
		.O_S_AXI_BRESP(bresp), .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(bre),
		.I_S_AXI_ARADDR(ara), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arr),
		.O_S_AXI_RDATA(rdat), .O_S_AXI_RRESP(rresp), .O_S_AXI_RVALID(rv),
		.I_S_AXI_RREADY(rre), .O_PWM(pwm));
	fpg_load fpg_load_i (.i_clk(clk), .i_clr(clr), .i_pwm(pwm), .o_rise(rise),
		.o_gap(gap), .o_high(hi), .o_t(tr));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// ==========================================================
	// Helpers
	function automatic logic [7:0] ca(int c, logic [3:0] o);
		return fpg_pkg::OFS_CH0 + 8'(c * 16) + {4'h0, o};
	endfunction
	function automatic int cyc(int t, int k);
		return t * fpg_pkg::SYS_KHZ / k;
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic near(input string n, input int g, input int e);
		chk(n, 32'(g >= e - 1 && g <= e + 1), 32'h1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge clk);
		awa <= a;
		wd <= x;
		{awv, wv, bre} <= 3'h7;
		forever begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
			if (bv) begin
				r = bresp;
				bre <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		ara <= a;
		{arv, rre} <= 2'h3;
		forever begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
			if (rv) begin
				d = rdat;
				r = rresp;
				rre <= 1'b0;
				break;
			end
		end
	endtask
	task automatic cfg(int c, int p, int h, int n, int ph);
		wr(ca(c, fpg_pkg::OFS_PERIOD), 32'(p));
		wr(ca(c, fpg_pkg::OFS_HIGH), 32'(h));
		wr(ca(c, fpg_pkg::OFS_COUNT), 32'(n));
		wr(ca(c, fpg_pkg::OFS_PHASE), 32'(ph));
	endtask
	task automatic end_sim;
		$display("Mismatches %0d in %0d compares", err_count, n_compared);
		if (err_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		end_sim;
	end
	// ==========================================================
	// Tests
	initial begin
		{nrst, awv, wv, bre, arv, rre, clr} = 7'h00;
		{awa, ara, wd} = 48'h0;
		ws = 4'hF;
		void'($urandom(32'hA97F));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rd(fpg_pkg::OFS_CTRL);
		chk("ctrl reset", d, fpg_pkg::CTRL_RST);
		for (int c = 0; c < 4; c++) begin
			rd(ca(c, fpg_pkg::OFS_PERIOD));
			chk("period reset", d, 32'(fpg_pkg::PERIOD_RST));
			rd(ca(c, fpg_pkg::OFS_HIGH));
			chk("high reset", d, 32'(fpg_pkg::HIGH_RST));
			v[c] = $urandom;
			wr(ca(c, fpg_pkg::OFS_PERIOD), v[c]);
		end
		for (int c = 0; c < 4; c++) begin
			rd(ca(c, fpg_pkg::OFS_PERIOD));
			chk("period", d, v[c] & 32'h3FFF_FFFF);
		end
		// Byte enables: only the two low bytes may change
		ws <= 4'h3;
		wr(ca(1, fpg_pkg::OFS_PERIOD), 32'hFFFF_FFFF);
		ws <= 4'hF;
		rd(ca(1, fpg_pkg::OFS_PERIOD));
		chk("strobe", d, (v[1] & 32'h3FFF_0000) | 32'h0000_FFFF);
		rd(8'h08);
		chk("unmapped resp", 32'(r), 32'(fpg_pkg::RESP_SLVERR));
		chk("unmapped data", d, 32'h0000_0000);
		wr(8'h12, 32'h5);
		chk("unaligned resp", 32'(r), 32'(fpg_pkg::RESP_SLVERR));
		for (int c = 0; c < 4; c++) begin
			pp[c] = (c == 3) ? 2 : 3 + $urandom_range(5);
			hh[c] = 1 + $urandom_range(pp[c] - 2);
			cfg(c, (c == 3) ? 0 : pp[c], hh[c], 1, 0);
		end
		wr(fpg_pkg::OFS_CTRL, 32'h0000_000F);
		repeat (150) @(posedge clk);
		for (int c = 0; c < 4; c++) begin
			near("gap", gap[c], cyc(pp[c], fpg_pkg::SRC_A_KHZ));
			near("high", hi[c], cyc(hh[c], fpg_pkg::SRC_A_KHZ));
		end
		wr(ca(0, fpg_pkg::OFS_PERIOD), 32'h7);
		wr(fpg_pkg::OFS_CTRL, 32'h0000_010F);
		repeat (150) @(posedge clk);
		near("gap fast", gap[0], cyc(7, fpg_pkg::SRC_B_KHZ));
		near("high fast", hi[0], cyc(hh[0], fpg_pkg::SRC_B_KHZ));
		wr(fpg_pkg::OFS_CTRL, 32'h0);
		repeat (5) @(posedge clk);
		chk("stopped", 32'(pwm), 32'h0);
		cfg(2, 4, 2, 3, 0);
		cfg(1, 32'h3FFF_FFFF, 4, 1, 0);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wr(fpg_pkg::OFS_CTRL, 32'h0000_0046);
		repeat (100) @(posedge clk);
		chk("pulses", 32'(rise[2]), 32'h3);
		chk("long period", 32'(rise[1]), 32'h1);
		chk("held low", 32'(pwm[2]), 32'h0);
		rd(fpg_pkg::OFS_STATUS);
		chk("done active", 32'(d[6:2]), 32'h10);
		wr(fpg_pkg::OFS_CTRL, 32'h0);
		for (int c = 0; c < 4; c++)
			cfg(c, 8, 4, 1, 2 * c);
		wr(fpg_pkg::OFS_CTRL, 32'h0000_0600);
		repeat (150) @(posedge clk);
		for (int c = 0; c < 4; c++)
			near("sync gap", gap[c], 20);
		near("offset", (tr[0] - tr[2] + 40) % 20, 10);
		end_sim;
	end
endmodule
